/* sfsr_defines.svh */
// constants for the serial flash status and read block
`ifndef SFSR_DEFINES_SVH
`define SFSR_DEFINES_SVH

// ****************************************************************
// instruction codes
// ****************************************************************
`define SFSR_WRITE_ENABLE_CMD 8'h06
`define SFSR_WRITE_DISABLE_CMD 8'h04
`define SFSR_READ_STATUS_CMD 8'h05
`define SFSR_WRITE_STATUS_CMD 8'h01
`define SFSR_READ_DATA_CMD 8'h03
`define SFSR_PAGE_PROGRAM_CMD 8'h02
`define SFSR_SECTOR_ERASE_CMD 8'h20
`define SFSR_BLOCK_ERASE_CMD_A 8'hD8
`define SFSR_BLOCK_ERASE_CMD_B 8'h52
`define SFSR_CHIP_ERASE_CMD_A 8'hC7
`define SFSR_CHIP_ERASE_CMD_B 8'h60
`define SFSR_ENTER_OTP_CMD 8'h3A

// ****************************************************************
// status byte layout and reset values
// ****************************************************************
`define SFSR_BUSY_BIT 0
`define SFSR_WLATCH_BIT 1
`define SFSR_PLEVEL_LSB 2
`define SFSR_PLEVEL_MSB 4
`define SFSR_LOCK_BIT 7
`define SFSR_PLEVEL_RESET 3'h0
`define SFSR_ADDR_MAX 24'hFFFFFF

// ****************************************************************
// byte counts and timing
// ****************************************************************
`define SFSR_BYTES_STATUS_WRITE 3'h2
`define SFSR_BYTES_ERASE 3'h4
`define SFSR_BYTES_PROGRAM_MIN 3'h5
`define SFSR_LAST_ADDR_BYTE 3'h3
`define SFSR_CLK_PERIOD_PS 8000
`define SFSR_TW_NS 5000
`define SFSR_TW_CYCLES ((`SFSR_TW_NS * 1000 + `SFSR_CLK_PERIOD_PS - 1) / `SFSR_CLK_PERIOD_PS)
`define SFSR_TIMER_W 10
`define SFSR_PIN_RESET 4'h3

`endif

/* sfsr_pkg.sv */
// types shared by the serial flash status and read block
package sfsr_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE, ST_ADDR, ST_WDATA, ST_STATUS, ST_READ, ST_TAIL, ST_IGNORE
  } sfsr_state_t;

  typedef enum logic [1:0] {
    OP_PROGRAM, OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_CHIP_ERASE
  } sfsr_op_t;
endpackage

/* sfsr_pin_sync.sv */
// three-stage synchroniser with agreement filter for the serial pins
`timescale 1ns/1ps
`include "sfsr_defines.svh"
module sfsr_pin_sync (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [3:0] pinIn,
  output logic [3:0] pinLevel
);
  logic [3:0] s1_reg, s2_reg, s3_reg, level_reg;
  logic [3:0] level_next;

  // the level only moves once stages two and three agree
  always_comb begin
    level_next = level_reg;
    for (int i = 0; i < 4; i++) begin
      if (s2_reg[i] == s3_reg[i]) begin
        level_next[i] = s3_reg[i];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      s1_reg <= `SFSR_PIN_RESET;
      s2_reg <= `SFSR_PIN_RESET;
      s3_reg <= `SFSR_PIN_RESET;
      level_reg <= `SFSR_PIN_RESET;
    end else begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      level_reg <= level_next;
    end
  end

  assign pinLevel = level_reg;
endmodule

/* sfsr_write_timer.sv */
// self-timed status write cycle counter
`timescale 1ns/1ps
`include "sfsr_defines.svh"
module sfsr_write_timer (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam logic [`SFSR_TIMER_W-1:0] LAST = `SFSR_TIMER_W'(`SFSR_TW_CYCLES - 1);
  logic [`SFSR_TIMER_W-1:0] count_reg, count_next;
  logic busy_reg, busy_next, done_reg, done_next;

  always_comb begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (busy_reg) begin
      if (count_reg == LAST) begin
        busy_next = 1'b0;
        done_next = 1'b1;
      end else begin
        count_next = count_reg + 1'b1;
      end
    end else if (start) begin
      busy_next = 1'b1;
      count_next = '0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;
endmodule

/* sfsr_flash_status.sv */
// serial flash status register, protection and array read path
// Overview of operation
// - read-status instruction is accepted anytime, even during a busy cycle
// - status byte repeats live until chip select rises
// - bit 0 shows a status write, program or erase in progress
// - bit 1 is the write latch; clear latch refuses writes
// - bits 4..2 protect levels block program and erases in their region
// - chip erase only runs with all protect levels zero
// - bits 6 and 5 always read zero
// - status write changes only bit 7 and bits 4..2
// - outside one-time mode, lock bit set with protect pin low freezes status and refuses status writes
// - in one-time mode bit 7 is a set-once sector lock
// - in one-time mode status write ignores data and sets the lock
// - status write needs an earlier write-enable instruction
// - status write must end exactly after the data byte
// - valid status write starts timed cycle, busy held, then latch cleared
// - read takes opcode and 24-bit address, data out on falling edges
// - read address increments per byte and wraps to zero
// - chip select rising ends a read anywhere
// - read during a busy cycle is rejected without disturbing it
// - everything travels most significant bit first
// - write-enable instruction sets the write latch
// - write-disable clears the latch, or leaves one-time mode
`timescale 1ns/1ps
`include "sfsr_defines.svh"
module sfsr_flash_status
  import sfsr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic spiClk,
  input wire logic chipSelectN,
  input wire logic serial_in,
  input wire logic writeProtectN,
  output logic serialOut,
  output logic serialOutEn,
  output logic [23:0] flashAddr,
  input wire logic [7:0] arrayRdData,
  output logic [2:0] protectLevel,
  input wire logic addrProtected,
  output logic opStart,
  output sfsr_op_t opKind,
  input wire logic engineBusy,
  output logic otpModeActive
);
  // ****************************************************************
  // pin sampling
  // ****************************************************************
  logic [3:0] pinLevel;
  logic clkLvl, csLvlN, dinLvl, wpLvlN;

  sfsr_pin_sync u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .pinIn({serial_in, writeProtectN, chipSelectN, spiClk}),
    .pinLevel(pinLevel)
  );
  assign clkLvl = pinLevel[0];
  assign csLvlN = pinLevel[1];
  assign wpLvlN = pinLevel[2];
  assign dinLvl = pinLevel[3];

  // ****************************************************************
  // state
  // ****************************************************************
  sfsr_state_t state_reg, state_next;
  logic [2:0] bitCnt_reg, bitCnt_next, byteCnt_reg, byteCnt_next;
  logic [7:0] opcode_reg, opcode_next, shiftIn_reg, shiftIn_next;
  logic [7:0] shiftOut_reg, shiftOut_next, wsrData_reg, wsrData_next;
  logic [7:0] pend_reg, pend_next;
  logic [23:0] addr_reg, addr_next;
  logic sout_reg, sout_next, soutEn_reg, soutEn_next;
  logic wel_reg, wel_next, lockBit_reg, lockBit_next;
  logic otpLock_reg, otpLock_next, otpMode_reg, otpMode_next;
  logic [2:0] plevel_reg, plevel_next;
  logic opStart_reg, opStart_next, busyPrev_reg;
  sfsr_op_t opKind_reg, opKind_next;
  logic clkPrev_reg, csPrevN_reg;

  logic wsrBusy, wsrDone, wsrStart;
  logic clkRise, clkFall, csRise, busyFlag, hwProtect, frameOk;
  logic [7:0] statusByte, shIn, loadByte;

  sfsr_write_timer u_timer (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .start(wsrStart),
    .busy(wsrBusy),
    .done(wsrDone)
  );

  function automatic logic [2:0] satInc(input logic [2:0] v);
    satInc = (v == 3'h7) ? v : v + 3'h1;
  endfunction

  assign clkRise = clkLvl & ~clkPrev_reg & ~csLvlN;
  assign clkFall = ~clkLvl & clkPrev_reg & ~csLvlN;
  assign csRise = csLvlN & ~csPrevN_reg;
  assign busyFlag = wsrBusy | engineBusy;
  // hardware protection only exists outside one-time mode
  assign hwProtect = lockBit_reg & ~wpLvlN & ~otpMode_reg;
  // reserved bits are hard zero; bit 7 shows the sector lock in one-time mode
  assign statusByte = {otpMode_reg ? otpLock_reg : lockBit_reg, 2'h0, plevel_reg,
                       wel_reg, busyFlag};
  assign shIn = {shiftIn_reg[6:0], dinLvl};
  // an instruction counts only if chip select rose at a byte boundary while idle
  assign frameOk = csRise & (bitCnt_reg == 3'h0) & ~busyFlag & (state_reg != ST_IGNORE);
  assign wsrStart = frameOk & (opcode_reg == `SFSR_WRITE_STATUS_CMD)
                    & (byteCnt_reg == `SFSR_BYTES_STATUS_WRITE)
                    & wel_reg & ~hwProtect;
  assign loadByte = (state_reg == ST_STATUS) ? statusByte : arrayRdData;

  // ****************************************************************
  // next-state logic
  // ****************************************************************
  always_comb begin
    state_next = state_reg;
    bitCnt_next = bitCnt_reg;
    byteCnt_next = byteCnt_reg;
    opcode_next = opcode_reg;
    shiftIn_next = shiftIn_reg;
    shiftOut_next = shiftOut_reg;
    wsrData_next = wsrData_reg;
    pend_next = pend_reg;
    addr_next = addr_reg;
    sout_next = sout_reg;
    soutEn_next = soutEn_reg;
    wel_next = wel_reg;
    lockBit_next = lockBit_reg;
    otpLock_next = otpLock_reg;
    otpMode_next = otpMode_reg;
    plevel_next = plevel_reg;
    opStart_next = 1'b0;
    opKind_next = opKind_reg;
    // cleared first so a write-enable taken in the same cycle still sets the latch
    if (busyPrev_reg && !busyFlag) begin
      wel_next = 1'b0;
    end
    if (csRise) begin
      // chip select rising always ends the frame, mid-byte included
      state_next = ST_OPCODE;
      bitCnt_next = 3'h0;
      byteCnt_next = 3'h0;
      soutEn_next = 1'b0;
      if (frameOk && byteCnt_reg == 3'h1) begin
        if (opcode_reg == `SFSR_WRITE_ENABLE_CMD) begin
          wel_next = 1'b1;
        end else if (opcode_reg == `SFSR_WRITE_DISABLE_CMD) begin
          if (otpMode_reg) begin
            otpMode_next = 1'b0;
          end else begin
            wel_next = 1'b0;
          end
        end else if (opcode_reg == `SFSR_ENTER_OTP_CMD) begin
          otpMode_next = 1'b1;
        end else if ((opcode_reg == `SFSR_CHIP_ERASE_CMD_A ||
                      opcode_reg == `SFSR_CHIP_ERASE_CMD_B) &&
                     wel_reg && plevel_reg == 3'h0 && !otpMode_reg) begin
          opStart_next = 1'b1;
          opKind_next = OP_CHIP_ERASE;
        end
      end
      if (wsrStart) begin
        pend_next = wsrData_reg;
      end
      // region blocking: the external table judges the address, the lock guards one-time
      if (frameOk && wel_reg && !(otpMode_reg ? otpLock_reg : addrProtected)) begin
        if (opcode_reg == `SFSR_PAGE_PROGRAM_CMD &&
            byteCnt_reg >= `SFSR_BYTES_PROGRAM_MIN) begin
          opStart_next = 1'b1;
          opKind_next = OP_PROGRAM;
        end else if (byteCnt_reg == `SFSR_BYTES_ERASE &&
                     opcode_reg == `SFSR_SECTOR_ERASE_CMD) begin
          opStart_next = 1'b1;
          opKind_next = OP_SECTOR_ERASE;
        end else if (byteCnt_reg == `SFSR_BYTES_ERASE &&
                     (opcode_reg == `SFSR_BLOCK_ERASE_CMD_A ||
                      opcode_reg == `SFSR_BLOCK_ERASE_CMD_B)) begin
          opStart_next = 1'b1;
          opKind_next = OP_BLOCK_ERASE;
        end
      end
    end else if (clkRise) begin
      bitCnt_next = bitCnt_reg + 3'h1;
      shiftIn_next = shIn;
      if (bitCnt_reg == 3'h7) begin
        byteCnt_next = satInc(byteCnt_reg);
        case (state_reg)
          ST_OPCODE: begin
            opcode_next = shIn;
            if (shIn == `SFSR_READ_STATUS_CMD) begin
              state_next = ST_STATUS;
            end else if (shIn == `SFSR_READ_DATA_CMD) begin
              state_next = busyFlag ? ST_IGNORE : ST_ADDR;
            end else if (shIn == `SFSR_WRITE_STATUS_CMD) begin
              state_next = ST_WDATA;
            end else if (shIn == `SFSR_PAGE_PROGRAM_CMD || shIn == `SFSR_SECTOR_ERASE_CMD ||
                         shIn == `SFSR_BLOCK_ERASE_CMD_A ||
                         shIn == `SFSR_BLOCK_ERASE_CMD_B) begin
              state_next = ST_ADDR;
            end else begin
              state_next = ST_TAIL;
            end
          end
          ST_ADDR: begin
            addr_next = {addr_reg[15:0], shIn};
            if (byteCnt_reg == `SFSR_LAST_ADDR_BYTE) begin
              state_next = (opcode_reg == `SFSR_READ_DATA_CMD) ? ST_READ : ST_TAIL;
            end
          end
          ST_WDATA: begin
            wsrData_next = shIn;
            state_next = ST_TAIL;
          end
          default: begin
            state_next = state_reg;
          end
        endcase
      end
    end else if (clkFall && (state_reg == ST_STATUS || state_reg == ST_READ)) begin
      soutEn_next = 1'b1;
      if (bitCnt_reg == 3'h0) begin
        // reload at each byte start so the status byte stays live
        sout_next = loadByte[7];
        shiftOut_next = {loadByte[6:0], 1'b0};
        if (state_reg == ST_READ) begin
          addr_next = addr_reg + 24'h1;
        end
      end else begin
        sout_next = shiftOut_reg[7];
        shiftOut_next = {shiftOut_reg[6:0], 1'b0};
      end
    end
    // cycle completion: apply the written bits; the latch drops in the same cycle
    if (wsrDone) begin
      if (otpMode_reg) begin
        otpLock_next = 1'b1;
      end else begin
        lockBit_next = pend_reg[`SFSR_LOCK_BIT];
        plevel_next = pend_reg[`SFSR_PLEVEL_MSB:`SFSR_PLEVEL_LSB];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_reg <= ST_OPCODE;
      bitCnt_reg <= 3'h0;
      byteCnt_reg <= 3'h0;
      opcode_reg <= 8'h00;
      shiftIn_reg <= 8'h00;
      shiftOut_reg <= 8'h00;
      wsrData_reg <= 8'h00;
      pend_reg <= 8'h00;
      addr_reg <= 24'h000000;
      sout_reg <= 1'b0;
      soutEn_reg <= 1'b0;
      wel_reg <= 1'b0;
      lockBit_reg <= 1'b0;
      otpLock_reg <= 1'b0;
      otpMode_reg <= 1'b0;
      plevel_reg <= `SFSR_PLEVEL_RESET;
      opStart_reg <= 1'b0;
      opKind_reg <= OP_PROGRAM;
      busyPrev_reg <= 1'b0;
      clkPrev_reg <= 1'b1;
      csPrevN_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      bitCnt_reg <= bitCnt_next;
      byteCnt_reg <= byteCnt_next;
      opcode_reg <= opcode_next;
      shiftIn_reg <= shiftIn_next;
      shiftOut_reg <= shiftOut_next;
      wsrData_reg <= wsrData_next;
      pend_reg <= pend_next;
      addr_reg <= addr_next;
      sout_reg <= sout_next;
      soutEn_reg <= soutEn_next;
      wel_reg <= wel_next;
      lockBit_reg <= lockBit_next;
      otpLock_reg <= otpLock_next;
      otpMode_reg <= otpMode_next;
      plevel_reg <= plevel_next;
      opStart_reg <= opStart_next;
      opKind_reg <= opKind_next;
      busyPrev_reg <= busyFlag;
      clkPrev_reg <= clkLvl;
      csPrevN_reg <= csLvlN;
    end
  end

  assign serialOut = sout_reg;
  assign serialOutEn = soutEn_reg;
  assign flashAddr = addr_reg;
  assign protectLevel = plevel_reg;
  assign opStart = opStart_reg;
  assign opKind = opKind_reg;
  assign otpModeActive = otpMode_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  sequence statusLoad;
    clkFall && state_reg == ST_STATUS && bitCnt_reg == 3'h0 && !csRise;
  endsequence
  sequence wsrLaunch;
    wsrStart && !busyFlag;
  endsequence
  sequence readWhileBusy;
    clkRise && !csRise && state_reg == ST_OPCODE && bitCnt_reg == 3'h7 &&
      shIn == `SFSR_READ_DATA_CMD && busyFlag;
  endsequence

  status_live_a: assert property (statusLoad |=> serialOut == $past(statusByte[7])
    && serialOutEn) else $error("status byte not shifted out live");
  reserved_zero_a: assert property (statusByte[6:5] == 2'h0)
    else $error("reserved status bits not zero");
  wsr_cycle_a: assert property (wsrLaunch |=> busyFlag[*8] ##[1:700] !wsrBusy)
    else $error("status write cycle timing wrong");
  wel_gate_a: assert property (opStart |-> $past(wel_reg))
    else $error("operation started without write latch");
  chip_erase_a: assert property (opStart && opKind == OP_CHIP_ERASE |-> plevel_reg == 3'h0)
    else $error("chip erase under protection");
  wsr_apply_a: assert property (wsrDone && !otpMode_reg |=>
    plevel_reg == $past(pend_reg[4:2]) && lockBit_reg == $past(pend_reg[7]))
    else $error("status write applied wrong bits");
  hw_protect_a: assert property (csRise && hwProtect |-> !wsrStart)
    else $error("status write taken under hardware protection");
  otp_lock_a: assert property (wsrDone && otpMode_reg |=> otpLock_reg && statusByte[7])
    else $error("one-time lock not set");
  addr_wrap_a: assert property (clkFall && state_reg == ST_READ && bitCnt_reg == 3'h0 &&
    !csRise && addr_reg == `SFSR_ADDR_MAX |=> addr_reg == 24'h000000)
    else $error("read address did not wrap");
  read_end_a: assert property (csRise |=> !serialOutEn && state_reg == ST_OPCODE)
    else $error("frame not ended by chip select");
  read_reject_a: assert property (readWhileBusy |=> state_reg == ST_IGNORE &&
    (wsrBusy || wsrDone || !$past(wsrBusy))) else $error("read accepted during busy cycle");
  latch_clear_a: assert property (busyPrev_reg && !busyFlag && !csRise |=> !wel_reg)
    else $error("write latch not cleared after cycle");
endmodule

/* sfsr_host_model.sv */
// host side serial master model that drives the flash status block pins
`timescale 1ns/1ps
module sfsr_host_model (
  input wire logic ref_clk,
  output logic spiClk,
  output logic chipSelectN,
  output logic serial_in,
  input wire logic serialOut
);
  logic [7:0] rxq[$];

  initial begin
    spiClk = 1'b1;
    chipSelectN = 1'b1;
    serial_in = 1'b0;
  end

  // ****************************************************************
  // bit and frame shifting, clock idles high between frames
  // ****************************************************************
  // data changes with the falling clock and stays put across the rise
  // sampling waits a whole period: the block answers about 40 ns after the fall
  task automatic bitx(input logic din, output logic dout);
    spiClk <= 1'b0;
    serial_in <= din;
    repeat (4) @(posedge ref_clk);
    spiClk <= 1'b1;
    repeat (4) @(posedge ref_clk);
    dout = serialOut;
  endtask

  task automatic frame(input logic [7:0] tx[$], input int nrx, input int tail);
    logic [7:0] b;
    logic v;
    rxq.delete();
    chipSelectN <= 1'b0;
    repeat (4) @(posedge ref_clk);
    foreach (tx[i]) begin
      for (int k = 7; k >= 0; k--) bitx(tx[i][k], v);
    end
    for (int n = 0; n < nrx; n++) begin
      for (int k = 7; k >= 0; k--) begin
        bitx(1'b0, v);
        b[k] = v;
      end
      rxq.push_back(b);
    end
    for (int k = 0; k < tail; k++) bitx(1'b1, v);
    repeat (4) @(posedge ref_clk);
    chipSelectN <= 1'b1;
    // a released line must not keep showing its last level
    serial_in <= ~serial_in;
    repeat (12) @(posedge ref_clk);
  endtask
endmodule

/* sfsr_flash_status_bench.sv */
// self-checking bench for the serial flash status and read block
`timescale 1ns/1ps
module sfsr_flash_status_bench
  import sfsr_pkg::*;
();
  logic ref_clk, rstn, spiClk, chipSelectN, serial_in, serialOut, serialOutEn;
  logic writeProtectN, addrProtected, opStart, otpModeActive;
  logic engineBusy = 1'b0;
  logic [23:0] flashAddr, a;
  logic [7:0] arrayRdData, s, d;
  logic [7:0] q[$], r[$];
  logic [2:0] protectLevel, lvl;
  sfsr_op_t opKind, lastKind;
  int fail_count, cmp_count, n, m;
  int cycles = 0, starts = 0, busyLeft = 0, oeCount = 0;
  sfsr_op_t knd[7] = '{OP_SECTOR_ERASE, OP_BLOCK_ERASE, OP_BLOCK_ERASE, OP_PROGRAM,
    OP_CHIP_ERASE, OP_CHIP_ERASE, OP_SECTOR_ERASE};
  logic [7:0] opc[7] = '{8'h20, 8'hD8, 8'h52, 8'h02, 8'hC7, 8'h60, 8'h20};
  int nb[7] = '{3, 3, 3, 4, 0, 0, 3};
  // bit i belongs to table entry i
  logic [6:0] prt = 7'h05;
  logic [6:0] go = 7'h6A;

  sfsr_flash_status sfsr_flash_status_i (.ref_clk, .rstn, .spiClk, .chipSelectN, .serial_in,
    .writeProtectN, .serialOut, .serialOutEn, .flashAddr, .arrayRdData, .protectLevel,
    .addrProtected, .opStart, .opKind, .engineBusy, .otpModeActive);
  sfsr_host_model sfsr_host_model_i (.ref_clk, .spiClk, .chipSelectN, .serial_in, .serialOut);

  function automatic logic [7:0] arr_of(input logic [23:0] x);
    return x[7:0] ^ x[23:16] ^ 8'hA5;
  endfunction
  assign arrayRdData = arr_of(flashAddr);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // engine stand-in, monitors and hang limit
  // ****************************************************************
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (serialOutEn === 1'b1) oeCount <= oeCount + 1;
    if (opStart === 1'b1) begin
      starts <= starts + 1;
      lastKind <= opKind;
      busyLeft <= 300;
    end else if (busyLeft > 0) begin
      busyLeft <= busyLeft - 1;
    end
    engineBusy <= opStart === 1'b1 || busyLeft > 1;
    if (cycles == 60000) begin
      fail_count++;
      print_verdict;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] expv, input string what);
    cmp_count++;
    if (seen !== expv) begin
      fail_count++;
      $display("MISMATCH %0t %s seen %0h expected %0h", $time, what, seen, expv);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic send(input logic [7:0] tx[$], input int nrx = 0, input int tail = 0);
    sfsr_host_model_i.frame(tx, nrx, tail);
    r = sfsr_host_model_i.rxq;
  endtask

  task automatic read_status_cmd;
    send({8'h05}, 1);
    s = r[0];
  endtask

  task automatic write_status_cmd(input logic [7:0] v);
    send({8'h06});
    send({8'h01, v});
  endtask

  // the last poll may straddle the busy fall, so one more read gives a settled byte
  task automatic wait_idle;
    int t;
    t = 0;
    do begin
      read_status_cmd;
      t++;
    end while (s[0] !== 1'b0 && t < 30);
    chk(t < 30, 1, "busy stuck");
    read_status_cmd;
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    rstn = 1'b0;
    writeProtectN = 1'b1;
    addrProtected = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    void'($urandom(2));
    repeat (6) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (8) @(posedge ref_clk);
    chk(protectLevel, 0, "level at reset");
    read_status_cmd;
    chk(s, 8'h00, "status at reset");
    chk(s & 8'h9F, 8'h00, "masked status");
    send({8'h06});
    send({8'h05}, 3);
    foreach (r[i]) chk(r[i], 8'h02, "latch repeated");
    send({8'h04});
    read_status_cmd;
    chk(s, 8'h00, "latch cleared");
    send({8'h01, 8'h9C});
    read_status_cmd;
    chk(s, 8'h00, "write without latch");
    send({8'h06});
    send({8'h01, 8'h1C}, 0, 3);
    send({8'h01, 8'h1C, 8'h00});
    read_status_cmd;
    chk(s, 8'h02, "bad frame length");
    d = (8'($urandom) & 8'h7F) | 8'h63;
    write_status_cmd(d);
    read_status_cmd;
    chk(s, 8'h03, "busy during write");
    m = oeCount;
    send({8'h03, 8'h00, 8'h00, 8'h10}, 1);
    chk(oeCount - m, 0, "read while busy");
    wait_idle;
    chk(s, {3'b000, d[4:2], 2'b00}, "status written");
    chk(protectLevel, d[4:2], "level output");
    for (int k = 0; k < 2; k++) begin
      a = k ? 24'($urandom) : 24'hFFFFFE;
      n = k ? $urandom_range(3, 1) : 4;
      send({8'h03, a[23:16], a[15:8], a[7:0]}, n);
      foreach (r[i]) chk(r[i], arr_of(a + 24'(i)), "array byte");
    end
    send({8'h03, a[23:16], a[15:8], a[7:0]}, 0, 3);
    chk(serialOutEn, 1'b0, "read ended mid-byte");
    for (int i = 0; i < 7; i++) begin
      if (i == 0 || i == 5) begin
        write_status_cmd(i == 0 ? 8'h1C : 8'h00);
        wait_idle;
      end
      lvl = i < 5 ? 3'h7 : 3'h0;
      addrProtected <= prt[i];
      n = starts;
      q = {opc[i]};
      repeat (nb[i]) q.push_back(8'($urandom));
      send({8'h06});
      send(q);
      chk(starts - n, go[i], "engine start");
      if (go[i]) chk(lastKind, knd[i], "engine kind");
      read_status_cmd;
      chk(s[0], go[i], "busy from engine");
      wait_idle;
      chk(s, {3'b000, lvl, ~go[i], 1'b0}, "latch after op");
    end
    write_status_cmd(8'h9C);
    wait_idle;
    chk(s, 8'h9C, "lock and level set");
    writeProtectN <= 1'b0;
    write_status_cmd(8'h00);
    read_status_cmd;
    chk(s, 8'h9E, "hardware protect");
    writeProtectN <= 1'b1;
    // levels and lock cleared ahead of one-time mode
    write_status_cmd(8'h00);
    wait_idle;
    chk(s, 8'h00, "protect released");
    send({8'h3A});
    chk(otpModeActive, 1'b1, "one-time mode");
    write_status_cmd(8'($urandom) & 8'h7F);
    wait_idle;
    chk(s, 8'h80, "one-time lock set");
    n = starts;
    send({8'h06});
    send({8'h02, 8'h00, 8'h01, 8'h00, 8'h55});
    chk(starts - n, 0, "locked sector program");
    write_status_cmd(8'h00);
    wait_idle;
    chk(s & 8'hFD, 8'h80, "lock stays set");
    send({8'h04});
    chk(otpModeActive, 1'b0, "normal mode again");
    print_verdict;
  end
endmodule
